// file: shared/nps_pkg.sv
// Purpose: shared constants and types for the page program sequencer
// Assumes: one 25 MHz clock for both ends
// Notes: status byte layout and command codes are common to both ends
package nps_pkg;
  // ==================================================
  // command codes
  localparam logic [7:0] CMD_PROG_OPEN = 8'h80;
  localparam logic [7:0] CMD_CONFIRM_PROG = 8'h10;
  localparam logic [7:0] CMD_CONFIRM_CACHE = 8'h15;
  localparam logic [7:0] CMD_CONFIRM_QUEUE = 8'h11;
  localparam logic [7:0] CMD_CHANGE_WRITE = 8'h85;
  localparam logic [7:0] CMD_STATUS_ALL = 8'h70;
  localparam logic [7:0] CMD_STATUS_SEL = 8'h78;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_RESET_SYNC = 8'hfc;

  // ==================================================
  // address layout
  localparam logic [2:0] PROG_ADDR_CYCLES = 3'h5;
  localparam logic [1:0] SEL_ADDR_CYCLES = 2'h3;
  localparam int PLANE_BIT = 7;
  localparam int NUM_PLANES = 2;

  // ==================================================
  // status byte bits
  localparam int ST_FAIL = 0;
  localparam int ST_PREV_CFAIL = 1;
  localparam int ST_ARR_RDY = 5;
  localparam int ST_RDY = 6;
  localparam int ST_WP_N = 7;

  // ==================================================
  // timing; busy times are longest figures, so they round down
  localparam int CLK_PERIOD_NS = 40;
  localparam int CACHE_BUSY_TIME_NS = 3000;
  localparam int PLANE_QUEUE_BUSY_TIME_NS = 500;
  localparam int PAGE_PROGRAM_TIME_NS = 100000;
  localparam int CACHE_BUSY_CYC =
    (CACHE_BUSY_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : CACHE_BUSY_TIME_NS / CLK_PERIOD_NS;
  localparam int PLANE_QUEUE_BUSY_CYC =
    (PLANE_QUEUE_BUSY_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : PLANE_QUEUE_BUSY_TIME_NS / CLK_PERIOD_NS;
  localparam int PAGE_PROGRAM_CYC =
    (PAGE_PROGRAM_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : PAGE_PROGRAM_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 20;

  // ==================================================
  // controller register map (byte addresses)
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STATREQ = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam int HST_LUN_READY = 0;
  localparam int HST_SEQ_BUSY = 1;
  localparam int IRQ_READY = 0;
  localparam int IRQ_STAT_DONE = 1;
  localparam int IRQ_FAIL = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // ==================================================
  // state types
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_LOAD = 7'h02,
    S_WAIT = 7'h04,
    S_CBSY = 7'h08,
    S_DBSY = 7'h10,
    S_PROG = 7'h20,
    S_SPARE = 7'h40
  } nps_lun_st_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h1,
    H_SEQ = 3'h2,
    H_WAIT = 3'h4
  } nps_host_st_t;
endpackage

// file: shared/nps_if.sv
// Purpose: pin bundle between flash controller and logical unit
// Assumes: all signals synchronous to the common clock
// Notes: wr with cle is a command, with ale an address, alone data
`timescale 1ns/1ps
interface nps_if;
  logic cle;
  logic ale;
  logic wr;
  logic rd;
  logic [7:0] dq_w;
  logic [7:0] dq_r;
  logic dq_r_vld;
  logic lun_ready;

  modport dev (
    input cle,
    input ale,
    input wr,
    input rd,
    input dq_w,
    output dq_r,
    output dq_r_vld,
    output lun_ready
  );

  modport host (
    output cle,
    output ale,
    output wr,
    output rd,
    output dq_w,
    input dq_r,
    input dq_r_vld,
    input lun_ready
  );
endinterface

// file: rtl/nps_lun.sv
// Purpose: logical unit end of the page program sequencer
// Assumes: host keeps the command order and spacing given below
// Notes: two planes, a small modelled array, status via 70h/78h
//
// Contract
// - program is 80h, five addresses, data, 10h
// - accept program when ready, array may be busy
// - 80h clears caches unless queue preceded it
// - data from column; 85h redirects column or row
// - 10h keeps unit busy until all planes programmed
// - host reads status with 78h, never 70h
// - cached program is 80h, addresses, data, 15h
// - after 15h busy cache time, copy, start array
// - ready but array busy shows previous cached fail
// - host polls array ready, then checks both fails
// - cache freed once copied into data register
// - queue entry ends 11h, short queue busy time
// - queue accepted when ready; more or final follows
// - final confirm programs all queued planes together
// - multi-plane 15h copies each plane, then programs
// - host programs pages in ascending order
// - while busy only status and reset accepted
//
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module nps_lun
  import nps_pkg::*;
#(
  parameter int COLS = 4320,
  parameter int MODEL_PAGES = 4,
  parameter int PROG_CYC = PAGE_PROGRAM_CYC,
  parameter int CBSY_CYC = CACHE_BUSY_CYC,
  parameter int DBSY_CYC = PLANE_QUEUE_BUSY_CYC,
  localparam int COL_W = $clog2(COLS),
  localparam int PG_W = $clog2(MODEL_PAGES)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // flash pins
  nps_if.dev pins,
  // array side
  input wire logic prog_fail_i,
  input wire logic peek_plane_i,
  input wire logic [PG_W-1:0] peek_page_i,
  input wire logic [COL_W-1:0] peek_col_i,
  output logic [7:0] peek_data_o
);

  // ==================================================
  // decode
  nps_lun_st_t state_q;
  nps_lun_st_t state_d;
  logic cmd_v;
  logic adr_v;
  logic dat_v;
  logic reset_cmd;
  logic loading;
  logic copy_go;
  logic arr_fin;
  logic cache_clr;
  logic cache_wr;
  logic cur_plane;
  logic [2:0] abyte_q;
  logic [15:0] col_q;
  logic [23:0] row_q;
  logic [NUM_PLANES-1:0] queued_q;
  logic [PG_W-1:0] qpage_q [NUM_PLANES];
  logic cached_q;
  logic [CNT_W-1:0] bsy_cnt_q;
  logic arr_busy_q;
  logic [CNT_W-1:0] arr_cnt_q;
  logic [NUM_PLANES-1:0] arr_planes_q;
  logic [PG_W-1:0] arr_page_q [NUM_PLANES];
  logic [NUM_PLANES-1:0] fail_q;
  logic [NUM_PLANES-1:0] cfail_q;
  logic [NUM_PLANES-1:0] cfail_view;
  logic [1:0] sel_cnt_q;
  logic st_all_q;
  logic st_plane_q;
  logic [7:0] st_byte;
  logic ready_q;
  logic [7:0] dq_r_q;
  logic dq_r_vld_q;
  logic [7:0] cache_q [NUM_PLANES][COLS];
  logic [7:0] dreg_q [NUM_PLANES][COLS];
  logic [7:0] arr_q [NUM_PLANES][MODEL_PAGES][COLS];

  function automatic logic is_busy(input nps_lun_st_t s);
    return (s == S_WAIT) || (s == S_CBSY) || (s == S_DBSY) || (s == S_PROG);
  endfunction

  assign cmd_v = pins.wr & pins.cle;
  assign adr_v = pins.wr & pins.ale & ~pins.cle;
  assign dat_v = pins.wr & ~pins.cle & ~pins.ale;
  // reset codes work in every state
  assign reset_cmd = cmd_v & ((pins.dq_w == CMD_RESET) | (pins.dq_w == CMD_RESET_SYNC));
  assign loading = (state_q == S_LOAD);
  assign cur_plane = row_q[PLANE_BIT];
  assign arr_fin = arr_busy_q && (arr_cnt_q == CNT_W'(1));
  // clear only when no plane is queued
  assign cache_clr = cmd_v && !is_busy(state_q) && (pins.dq_w == CMD_PROG_OPEN) && (queued_q == '0);
  // data lands at the current column
  assign cache_wr = dat_v && loading && (col_q < 16'(COLS));

  // ==================================================
  // sequencing
  always_comb begin
    state_d = state_q;
    copy_go = 1'b0;
    if (reset_cmd) begin
      state_d = S_IDLE;
    end else begin
      unique case (state_q)
        S_IDLE, S_LOAD: begin
          // open accepted whenever ready, array state aside
          if (cmd_v && pins.dq_w == CMD_PROG_OPEN) begin
            state_d = S_LOAD;
          end else if (cmd_v && loading && pins.dq_w == CMD_CONFIRM_PROG) begin
            state_d = S_WAIT;
          end else if (cmd_v && loading && pins.dq_w == CMD_CONFIRM_CACHE) begin
            state_d = S_WAIT;
          // 11h queues and goes briefly busy
          end else if (cmd_v && loading && pins.dq_w == CMD_CONFIRM_QUEUE) begin
            state_d = S_DBSY;
          end
        end
        S_WAIT: begin
          // wait for the data register to free
          if (!arr_busy_q) begin
            copy_go = 1'b1;
            state_d = cached_q ? S_CBSY : S_PROG;
          end
        end
        S_CBSY: begin
          if (bsy_cnt_q == CNT_W'(1)) begin
            state_d = S_IDLE;
          end
        end
        S_DBSY: begin
          // ready again for more queue or final
          if (bsy_cnt_q == CNT_W'(1)) begin
            state_d = S_IDLE;
          end
        end
        S_PROG: begin
          // stays busy until the array finishes
          if (!arr_busy_q) begin
            state_d = S_IDLE;
          end
        end
        default: state_d = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==================================================
  // address, queue and busy timers
  always_ff @(posedge clk_i) begin
    if (rst_i || reset_cmd) begin
      abyte_q <= 3'h0;
      col_q <= 16'h0000;
      row_q <= 24'h000000;
      queued_q <= '0;
      qpage_q <= '{default: '0};
      cached_q <= 1'b0;
      bsy_cnt_q <= '0;
    end else begin
      if (cmd_v && !is_busy(state_q) && pins.dq_w == CMD_PROG_OPEN) begin
        abyte_q <= 3'h0;
      end
      if (cmd_v && loading && pins.dq_w == CMD_CHANGE_WRITE) begin
        abyte_q <= 3'h0;
      end
      if (adr_v && sel_cnt_q == 2'h0 && loading && abyte_q != PROG_ADDR_CYCLES) begin
        abyte_q <= abyte_q + 3'h1;
        case (abyte_q)
          3'h0: col_q[7:0] <= pins.dq_w;
          3'h1: col_q[15:8] <= pins.dq_w;
          3'h2: row_q[7:0] <= pins.dq_w;
          3'h3: row_q[15:8] <= pins.dq_w;
          default: row_q[23:16] <= pins.dq_w;
        endcase
      end else if (cache_wr || (dat_v && loading)) begin
        col_q <= col_q + 16'h0001;
      end
      // each confirm queues the addressed plane
      if (cmd_v && loading && (pins.dq_w == CMD_CONFIRM_PROG || pins.dq_w == CMD_CONFIRM_CACHE
          || pins.dq_w == CMD_CONFIRM_QUEUE)) begin
        queued_q[cur_plane] <= 1'b1;
        qpage_q[cur_plane] <= row_q[PG_W-1:0];
        cached_q <= (pins.dq_w == CMD_CONFIRM_CACHE);
        bsy_cnt_q <= CNT_W'(DBSY_CYC);
      end
      if (copy_go) begin
        queued_q <= '0;
        bsy_cnt_q <= CNT_W'(CBSY_CYC);
      end else if ((state_q == S_CBSY || state_q == S_DBSY) && bsy_cnt_q != '0) begin
        bsy_cnt_q <= bsy_cnt_q - CNT_W'(1);
      end
    end
  end

  // ==================================================
  // array engine; fail history per plane
  always_ff @(posedge clk_i) begin
    if (rst_i || reset_cmd) begin
      arr_busy_q <= 1'b0;
      arr_cnt_q <= '0;
      arr_planes_q <= '0;
      arr_page_q <= '{default: '0};
    end else if (copy_go) begin
      arr_busy_q <= 1'b1;
      arr_cnt_q <= CNT_W'(PROG_CYC);
      arr_planes_q <= queued_q;
      arr_page_q <= qpage_q;
    end else if (arr_busy_q) begin
      arr_cnt_q <= arr_cnt_q - CNT_W'(1);
      if (arr_fin) begin
        arr_busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fail_q <= '0;
      cfail_q <= '0;
    end else if (arr_fin) begin
      for (int p = 0; p < NUM_PLANES; p++) begin
        if (arr_planes_q[p]) begin
          // the older outcome moves to the cached flag
          cfail_q[p] <= fail_q[p];
          fail_q[p] <= prog_fail_i;
        end
      end
    end
  end

  // ==================================================
  // page storage; large arrays carry no reset
  always_ff @(posedge clk_i) begin
    if (cache_clr) begin
      cache_q <= '{default: '{default: 8'hff}};
    end else if (cache_wr) begin
      cache_q[cur_plane][col_q[COL_W-1:0]] <= pins.dq_w;
    end
    for (int p = 0; p < NUM_PLANES; p++) begin
      // copy frees the cache for the next load
      // each plane moves its own cache
      if (copy_go && queued_q[p]) begin
        dreg_q[p] <= cache_q[p];
      end
      if (arr_fin && arr_planes_q[p]) begin
        arr_q[p][arr_page_q[p]] <= dreg_q[p];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peek_data_o <= 8'h00;
    end else begin
      peek_data_o <= arr_q[peek_plane_i][peek_page_i][peek_col_i];
    end
  end

  // ==================================================
  // status select and read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_cnt_q <= 2'h0;
      st_all_q <= 1'b1;
      st_plane_q <= 1'b0;
    end else if (cmd_v && pins.dq_w == CMD_STATUS_ALL) begin
      st_all_q <= 1'b1;
      sel_cnt_q <= 2'h0;
    end else if (cmd_v && pins.dq_w == CMD_STATUS_SEL) begin
      sel_cnt_q <= SEL_ADDR_CYCLES;
    end else if (adr_v && sel_cnt_q != 2'h0) begin
      sel_cnt_q <= sel_cnt_q - 2'h1;
      if (sel_cnt_q == SEL_ADDR_CYCLES) begin
        st_plane_q <= pins.dq_w[PLANE_BIT];
        st_all_q <= 1'b0;
      end
    end
  end

  always_comb begin
    st_byte = 8'h00;
    st_byte[ST_FAIL] = st_all_q ? |fail_q : fail_q[st_plane_q];
    // array running, newest result is the previous program's
    cfail_view = arr_busy_q ? fail_q : cfail_q;
    st_byte[ST_PREV_CFAIL] = st_all_q ? |cfail_view : cfail_view[st_plane_q];
    st_byte[ST_RDY] = !is_busy(state_q);
    st_byte[ST_ARR_RDY] = !is_busy(state_q) && !arr_busy_q;
    st_byte[ST_WP_N] = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_q <= 1'b1;
      dq_r_q <= 8'h00;
      dq_r_vld_q <= 1'b0;
    end else begin
      ready_q <= !is_busy(state_d);
      dq_r_vld_q <= pins.rd;
      if (pins.rd) begin
        dq_r_q <= st_byte;
      end
    end
  end

  assign pins.lun_ready = ready_q;
  assign pins.dq_r = dq_r_q;
  assign pins.dq_r_vld = dq_r_vld_q;
endmodule

// file: rtl/nps_host.sv
// Purpose: controller end; software steers pin cycles over wishbone
// Assumes: classic single-cycle wishbone master
// Notes: status is always read with the select form
`timescale 1ns/1ps
module nps_host
  import nps_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // interrupt
  output logic irq_o,
  // flash pins
  nps_if.host pins
);

  // ==================================================
  // request decode
  nps_host_st_t st_q;
  logic [2:0] step_q;
  logic [23:0] srow_q;
  logic [7:0] stat_q;
  logic cle_q;
  logic ale_q;
  logic wr_q;
  logic rd_q;
  logic [7:0] dq_q;
  logic req;
  logic wr_en;
  logic open_hold;
  logic done_ev;
  logic rdy_d1_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [31:0] rd_mux;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = wb_we_i & wb_sel_i[0];
  // a new open waits for the unit to be ready
  assign open_hold = (wb_adr_i == REG_CMD) && (wb_dat_i[7:0] == CMD_PROG_OPEN) && !pins.lun_ready;
  assign done_ev = (st_q == H_WAIT) && pins.dq_r_vld;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      REG_CMD: begin
        rd_mux[HST_LUN_READY] = pins.lun_ready;
        rd_mux[HST_SEQ_BUSY] = (st_q != H_IDLE);
      end
      REG_STATUS: rd_mux[7:0] = stat_q;
      REG_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_q;
      REG_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ==================================================
  // pin cycles and bus answers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= H_IDLE;
      step_q <= 3'h0;
      srow_q <= 24'h000000;
      stat_q <= 8'h00;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      dq_q <= 8'h00;
    end else begin
      wb_ack_o <= 1'b0;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      unique case (st_q)
        H_IDLE: begin
          if (req && wr_en && wb_adr_i == REG_STATREQ) begin
            st_q <= H_SEQ;
            step_q <= 3'h0;
            srow_q <= wb_dat_i[23:0];
          end else if (req && !(wr_en && open_hold)) begin
            wb_ack_o <= 1'b1;
            wb_dat_o <= rd_mux;
            if (wr_en && wb_adr_i == REG_CMD) begin
              cle_q <= 1'b1;
              wr_q <= 1'b1;
              dq_q <= wb_dat_i[7:0];
            end else if (wr_en && wb_adr_i == REG_ADDR) begin
              ale_q <= 1'b1;
              wr_q <= 1'b1;
              dq_q <= wb_dat_i[7:0];
            end else if (wr_en && wb_adr_i == REG_DATA) begin
              wr_q <= 1'b1;
              dq_q <= wb_dat_i[7:0];
            end
          end
        end
        H_SEQ: begin
          // select form avoids several units answering
          step_q <= step_q + 3'h1;
          if (step_q == 3'h0) begin
            cle_q <= 1'b1;
            wr_q <= 1'b1;
            dq_q <= CMD_STATUS_SEL;
          end else if (step_q <= 3'(SEL_ADDR_CYCLES)) begin
            ale_q <= 1'b1;
            wr_q <= 1'b1;
            dq_q <= srow_q[7:0];
            srow_q <= {8'h00, srow_q[23:8]};
          end else begin
            rd_q <= 1'b1;
            st_q <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (pins.dq_r_vld) begin
            stat_q <= pins.dq_r;
            wb_ack_o <= 1'b1;
            wb_dat_o <= {24'h000000, pins.dq_r};
            st_q <= H_IDLE;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  assign pins.cle = cle_q;
  assign pins.ale = ale_q;
  assign pins.wr = wr_q;
  assign pins.rd = rd_q;
  assign pins.dq_w = dq_q;

  // ==================================================
  // interrupts; a set in the clearing cycle wins
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_READY] = pins.lun_ready & ~rdy_d1_q;
    irq_set[IRQ_STAT_DONE] = done_ev;
    // either fail flag raises the fail event
    irq_set[IRQ_FAIL] = done_ev & (pins.dq_r[ST_FAIL] | pins.dq_r[ST_PREV_CFAIL]);
    irq_clr = '0;
    if (req && st_q == H_IDLE && wr_en && wb_adr_i == REG_IRQ_STAT) begin
      irq_clr = wb_dat_i[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdy_d1_q <= 1'b1;
      irq_stat_q <= '0;
      irq_mask_q <= IRQ_MASK_RST;
      irq_o <= 1'b0;
    end else begin
      rdy_d1_q <= pins.lun_ready;
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      if (req && st_q == H_IDLE && wr_en && wb_adr_i == REG_IRQ_MASK) begin
        irq_mask_q <= wb_dat_i[IRQ_W-1:0];
      end
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end
endmodule

// file: test/nps_assertions.sv
// Purpose: pin-level checks between controller and logical unit
// Assumes: one clock, synchronous active-high reset
// Notes: busy counts follow the small values the bench sets
`timescale 1ns/1ps
module nps_assertions
  import nps_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pins
  input wire logic cle,
  input wire logic ale,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] dq_w,
  input wire logic dq_r_vld,
  input wire logic lun_ready
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic is_cmd;
  assign is_cmd = cle && wr;
  // ==================================================
  // confirms and busy phases
  prog_busy_a: assert property ((is_cmd && dq_w == CMD_CONFIRM_PROG) |=>
    !lun_ready[*8] ##[1:100] lun_ready) else $error("program busy phase wrong");
  cache_busy_a: assert property ((is_cmd && dq_w == CMD_CONFIRM_CACHE) |=>
    !lun_ready[*5] ##[1:60] lun_ready) else $error("cache busy phase wrong");
  queue_busy_a: assert property ((is_cmd && dq_w == CMD_CONFIRM_QUEUE) |=>
    !lun_ready[*3] ##[1:2] lun_ready) else $error("queue busy phase wrong");
  // ==================================================
  // host side framing
  open_held_a: assert property (!lun_ready |-> !(is_cmd && dq_w == CMD_PROG_OPEN))
    else $error("program opened while busy");
  select_status_a: assert property (!(is_cmd && dq_w == CMD_STATUS_ALL))
    else $error("broadcast status issued");
  one_kind_a: assert property (wr |-> !(cle && ale))
    else $error("command and address in one cycle");
  // ==================================================
  // status replies
  status_reply_a: assert property (rd |=> dq_r_vld)
    else $error("status reply missing");
  reply_cause_a: assert property (dq_r_vld |-> $past(rd))
    else $error("status reply without request");
  cover property (is_cmd && dq_w == CMD_CONFIRM_CACHE);
  cover property (is_cmd && dq_w == CMD_CONFIRM_QUEUE);
  cover property (rd && !lun_ready);
  cover property (is_cmd && dq_w == CMD_RESET);
endmodule

// file: test/nand_page_program_sequencer_bench.sv
// Purpose: bench joining controller and logical unit
// Assumes: small busy counts and 16 columns
// Notes: each access notes its expected word; a monitor compares
`timescale 1ns/1ps
module nand_page_program_sequencer_bench
  import nps_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, fail = 1'b0, pl = 1'b0;
  logic pk_v = 1'b0, pk_q = 1'b0, wb_ack_o, irq_o;
  logic [1:0] pg = 2'h0;
  logic [3:0] col = 4'h0;
  logic [7:0] adr = 8'h00, peek_data_o;
  logic [31:0] dat = 32'h0, rdat, wb_dat_o, got;
  logic [63:0] q[$];
  logic [63:0] e;
  logic [7:0] mem[2][4][16];
  int errors = 0, n_tests = 0;

  initial forever #20 clk_i = ~clk_i;

  nps_if u_nps_if();
  nps_lun #(.COLS(16), .PROG_CYC(20), .CBSY_CYC(5), .DBSY_CYC(3)) u_nps_lun (.clk_i(clk_i), .rst_i(rst_i),
    .pins(u_nps_if.dev), .prog_fail_i(fail), .peek_plane_i(pl), .peek_page_i(pg), .peek_col_i(col),
    .peek_data_o(peek_data_o));
  nps_host u_nps_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'h1), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_o(irq_o), .pins(u_nps_if.host));
  nps_assertions u_nps_assertions (.clk_i(clk_i), .rst_i(rst_i), .cle(u_nps_if.cle), .ale(u_nps_if.ale),
    .wr(u_nps_if.wr), .rd(u_nps_if.rd), .dq_w(u_nps_if.dq_w), .dq_r_vld(u_nps_if.dq_r_vld),
    .lun_ready(u_nps_if.lun_ready));

  // ==================================================
  // monitor: irq rides in bit 31 of bus results
  always @(posedge clk_i) begin
    pk_q <= pk_v;
    if (wb_ack_o === 1'b1 || pk_q) begin
      e = q.pop_front();
      got = pk_q ? {24'h0, peek_data_o} : {irq_o, wb_dat_o[30:0]};
      if (e[63:32] != 32'h0) begin
        n_tests++;
        if ((got & e[63:32]) !== (e[31:0] & e[63:32])) begin
          errors++;
          $display("mismatch at %0t: got %h expected %h", $time, got & e[63:32], e[31:0]);
        end
      end
    end
  end

  task automatic final_report();
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    final_report();
  end

  // ==================================================
  // bus and pin tasks
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w, input logic [31:0] m,
                    input logic [31:0] v);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    q.push_back({m, v});
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] b);
    wb(REG_CMD, {24'h0, b}, 1'b1, 32'h0, 32'h0);
  endtask
  task automatic ad(input logic [7:0] b);
    wb(REG_ADDR, {24'h0, b}, 1'b1, 32'h0, 32'h0);
  endtask
  task automatic st(input logic [7:0] r0, input logic [7:0] m, input logic [7:0] v);
    wb(REG_STATREQ, {24'h0, r0}, 1'b1, {24'h0, m}, {24'h0, v});
  endtask
  task automatic wait_rdy();
    do wb(REG_CMD, 32'h0, 1'b0, 32'h0, 32'h0); while (rdat[HST_LUN_READY] !== 1'b1);
  endtask
  task automatic open(input logic p, input logic [1:0] g, input logic [3:0] c);
    cmd(CMD_PROG_OPEN);
    ad({4'h0, c});
    ad(8'h00);
    ad({p, 5'h0, g});
    ad(8'h00);
    ad(8'h00);
  endtask
  task automatic load(input logic p, input logic [1:0] g, input int c, input int n);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      mem[p][g][c+i] = b;
      wb(REG_DATA, {24'h0, b}, 1'b1, 32'h0, 32'h0);
    end
  endtask
  task automatic pk(input logic p, input logic [1:0] g, input int c);
    @(posedge clk_i);
    pl <= p;
    pg <= g;
    col <= 4'(c);
    pk_v <= 1'b1;
    q.push_back({32'hff, 24'h0, mem[p][g][c]});
    @(posedge clk_i);
    pk_v <= 1'b0;
  endtask

  // ==================================================
  // scenarios
  initial begin
    void'($urandom(32'h85b0));
    foreach (mem[i, j, k]) mem[i][j][k] = 8'hff;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(REG_IRQ_MASK, 32'h0, 1'b0, 32'h7, {29'h0, IRQ_MASK_RST});
    wb(8'h1c, 32'h0, 1'b0, 32'h7fffffff, 32'h0);
    wb(REG_CMD, 32'h0, 1'b0, 32'h3, 32'h1);
    wb(REG_IRQ_MASK, 32'h7, 1'b1, 32'h0, 32'h0);
    open(1'b0, 2'h0, 4'h2);
    load(1'b0, 2'h0, 2, 3);
    cmd(CMD_CHANGE_WRITE);
    ad(8'h08);
    ad(8'h00);
    load(1'b0, 2'h0, 8, 1);
    cmd(CMD_CONFIRM_PROG);
    st(8'h00, 8'h60, 8'h00);
    wait_rdy();
    st(8'h00, 8'hff, 8'he0);
    wb(REG_IRQ_STAT, 32'h0, 1'b0, 32'h80000003, 32'h80000003);
    wb(REG_IRQ_STAT, 32'h7, 1'b1, 32'h0, 32'h0);
    wb(REG_IRQ_STAT, 32'h0, 1'b0, 32'h80000007, 32'h0);
    for (int c = 0; c < 9; c++) pk(1'b0, 2'h0, c);
    fail <= 1'b1;
    open(1'b0, 2'h1, 4'h0);
    load(1'b0, 2'h1, 0, 4);
    cmd(CMD_CONFIRM_CACHE);
    wait_rdy();
    st(8'h00, 8'h60, 8'h40);
    open(1'b0, 2'h2, 4'h0);
    load(1'b0, 2'h2, 0, 4);
    cmd(CMD_CONFIRM_CACHE);
    wait_rdy();
    fail <= 1'b0;
    st(8'h00, 8'h63, 8'h43);
    do st(8'h00, 8'h00, 8'h00); while (rdat[ST_ARR_RDY] !== 1'b1);
    st(8'h00, 8'hff, 8'he2);
    for (int c = 0; c < 4; c++) pk(1'b0, 2'h1, c);
    for (int c = 0; c < 4; c++) pk(1'b0, 2'h2, c);
    // reset during the array phase must free the unit at once
    open(1'b1, 2'h0, 4'h0);
    cmd(CMD_CONFIRM_CACHE);
    wait_rdy();
    cmd(CMD_RESET);
    st(8'h80, 8'h63, 8'h60);
    open(1'b0, 2'h3, 4'h0);
    load(1'b0, 2'h3, 0, 2);
    cmd(CMD_CONFIRM_QUEUE);
    // no wait: the open must be held while the queue is busy
    open(1'b1, 2'h3, 4'h4);
    load(1'b1, 2'h3, 4, 2);
    cmd(CMD_CONFIRM_PROG);
    wait_rdy();
    st(8'h80, 8'hff, 8'he0);
    for (int c = 0; c < 6; c++) pk(c[2], 2'h3, c);
    wb(REG_IRQ_MASK, 32'h0, 1'b1, 32'h0, 32'h0);
    final_report();
  end
endmodule
